// ### logic/pmb_pkg.sv
// Purpose: Constants and types for the PCI master burst local port
// Assumes: 32-bit PCI and 32-bit local bus, one 25 MHz PCI clock
// Notes: Active-low PCI and local strobes are kept active low on the pins
package pmb_pkg;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam logic [3:0] ST_IDLE = 4'h0;
	localparam logic [3:0] ST_ADDR_LOAD = 4'h1;
	localparam logic [3:0] ST_BUS_XACT = 4'h2;
	localparam logic [3:0] ST_BUS_TERM = 4'h3;
	localparam logic [3:0] END_NONE = 4'h0;
	localparam logic [3:0] END_NORMAL = 4'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_TWO = 16'h0002;
	// Command bit 0 set marks a write command
	localparam int CMD_WR_BIT = 0;

	typedef enum logic [4:0] {
		PMB_IDLE = 5'b00001,
		PMB_LOAD = 5'b00010,
		PMB_ADDR = 5'b00100,
		PMB_DATA = 5'b01000,
		PMB_TERM = 5'b10000
	} pmb_state_t;

	// PCI-side outputs: active low strobes, ad and cben, with enables for all but reqn
	typedef struct packed {
		logic reqn;
		logic framen;
		logic frame_oe;
		logic irdyn;
		logic irdy_oe;
		logic [DATA_W-1:0] ad;
		logic ad_oe;
		logic [3:0] cben;
		logic cbe_oe;
	} pmb_pci_out_t;
endpackage

// ### logic/pmb_master_burst.sv
// Purpose: Burst engine for a 32-bit PCI master with a 32-bit local master port
// Assumes: All inputs synchronous to i_clk; no wait states, no target termination
// Notes: Outputs are all registered; PCI enables are high while driving
`timescale 1ns/1ps
module pmb_master_burst (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Local master side
	input wire logic i_local_req_32_n,
	input wire logic [31:0] i_l_ad_in,
	input wire logic [3:0] i_local_cmd_be_in,
	input wire logic [15:0] i_burst_len_in,
	input wire logic i_local_ready_n,
	output logic o_local_grant_n,
	output logic [3:0] o_local_xfer_state,
	output logic [3:0] o_local_end_kind,
	output logic o_local_xfer_strobe_n,
	output logic [31:0] o_l_data_out,
	output logic [15:0] o_burst_remaining,
	// PCI side
	input wire logic i_gntn,
	input wire logic i_framen,
	input wire logic i_irdyn,
	input wire logic i_trdyn,
	input wire logic [31:0] i_ad,
	output logic o_reqn,
	output logic o_framen,
	output logic o_frame_oe,
	output logic o_irdyn,
	output logic o_irdy_oe,
	output logic [31:0] o_ad,
	output logic o_ad_oe,
	output logic [3:0] o_cben,
	output logic o_cbe_oe
);
	// ****************************************
	// Decode
	// ****************************************
	pmb_pkg::pmb_state_t state_q, state_d;
	pmb_pkg::pmb_pci_out_t pci_q, pci_d;
	logic [3:0] xstate_q, end_q;
	logic grant_n_q, strobe_n_q, write_q, req_seen_q, gnt_q, rdy_q;
	logic [15:0] cnt_q;
	logic [31:0] dout_q;

	wire req = !i_local_req_32_n;
	wire gnt = !i_gntn;
	wire rdy = !i_local_ready_n;
	wire bus_idle = i_framen && i_irdyn;
	// Phase completes on our own irdyn, trdyn pair
	wire phase_done = (state_q == pmb_pkg::PMB_DATA) && !pci_q.irdyn && !i_trdyn;
	wire last_phase = (cnt_q == pmb_pkg::CNT_ONE);
	// Read strobe lines up with the word it marks, so the local side takes both together
	wire rd_xfer = !write_q && phase_done && rdy;
	// Write words are taken at the address clock and at every phase but the final one
	wire wr_xfer = write_q && rdy
		&& (state_q == pmb_pkg::PMB_ADDR || (phase_done && !last_phase));

	// ****************************************
	// State and PCI drive
	// ****************************************
	always_comb begin
		state_d = state_q;
		pci_d = pci_q;
		pci_d.reqn = !(req_seen_q && state_q != pmb_pkg::PMB_DATA && state_q != pmb_pkg::PMB_TERM);
		case (state_q)
			pmb_pkg::PMB_IDLE: begin
				pci_d.irdy_oe = 1'b0;
				if (req_seen_q && gnt_q && req)
					state_d = pmb_pkg::PMB_LOAD;
			end
			pmb_pkg::PMB_LOAD: begin
				if (gnt) begin
					state_d = pmb_pkg::PMB_ADDR;
					pci_d.framen = 1'b0;
					pci_d.frame_oe = 1'b1;
					pci_d.ad = i_l_ad_in;
					pci_d.ad_oe = 1'b1;
					pci_d.cben = i_local_cmd_be_in;
					pci_d.cbe_oe = 1'b1;
				end
			end
			pmb_pkg::PMB_ADDR: begin
				state_d = pmb_pkg::PMB_DATA;
				pci_d.ad_oe = write_q;
				pci_d.ad = i_l_ad_in;
				pci_d.cben = i_local_cmd_be_in;
				pci_d.irdyn = !rdy_q;
				pci_d.irdy_oe = 1'b1;
				pci_d.framen = (cnt_q == pmb_pkg::CNT_ONE);
			end
			pmb_pkg::PMB_DATA: begin
				pci_d.irdyn = !rdy;
				if (phase_done && last_phase) begin
					state_d = pmb_pkg::PMB_TERM;
					pci_d.framen = 1'b1;
					pci_d.frame_oe = 1'b0;
					pci_d.cbe_oe = 1'b0;
					pci_d.ad_oe = 1'b0;
					pci_d.irdyn = 1'b1;
				end else begin
					// Frame drops as the final phase is entered
					pci_d.framen = phase_done && (cnt_q == pmb_pkg::CNT_TWO);
					if (phase_done && write_q) begin
						pci_d.ad = i_l_ad_in;
						pci_d.cben = i_local_cmd_be_in;
					end
				end
			end
			pmb_pkg::PMB_TERM: begin
				state_d = pmb_pkg::PMB_IDLE;
				pci_d.irdy_oe = 1'b0;
			end
			default: begin
				state_d = pmb_pkg::PMB_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_q <= pmb_pkg::PMB_IDLE;
			pci_q <= '{reqn: 1'b1, framen: 1'b1, irdyn: 1'b1, cben: 4'hf, default: '0};
		end else begin
			state_q <= state_d;
			pci_q <= pci_d;
		end
	end

	// ****************************************
	// Local side
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			xstate_q <= pmb_pkg::ST_IDLE;
			end_q <= pmb_pkg::END_NONE;
			grant_n_q <= 1'b1;
			strobe_n_q <= 1'b1;
			cnt_q <= pmb_pkg::CNT_ZERO;
			dout_q <= 32'h0000_0000;
			write_q <= 1'b0;
			req_seen_q <= 1'b0;
			gnt_q <= 1'b0;
			rdy_q <= 1'b0;
		end else begin
			req_seen_q <= req && (state_q == pmb_pkg::PMB_IDLE);
			gnt_q <= gnt;
			rdy_q <= rdy;
			grant_n_q <= !(gnt && bus_idle && req_seen_q);
			if (state_d == pmb_pkg::PMB_LOAD && state_q == pmb_pkg::PMB_IDLE) begin
				xstate_q <= pmb_pkg::ST_ADDR_LOAD;
				write_q <= i_local_cmd_be_in[pmb_pkg::CMD_WR_BIT];
			end
			if (state_d == pmb_pkg::PMB_ADDR) begin
				xstate_q <= pmb_pkg::ST_BUS_XACT;
				end_q <= pmb_pkg::END_NONE;
				cnt_q <= i_burst_len_in;
			end
			if (phase_done) begin
				cnt_q <= cnt_q - pmb_pkg::CNT_ONE;
				if (!write_q)
					dout_q <= i_ad;
			end
			if (state_d == pmb_pkg::PMB_TERM) begin
				xstate_q <= pmb_pkg::ST_BUS_TERM;
				end_q <= pmb_pkg::END_NORMAL;
			end
			if (state_q == pmb_pkg::PMB_TERM)
				xstate_q <= pmb_pkg::ST_IDLE;
			strobe_n_q <= !(rd_xfer || wr_xfer);
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_local_grant_n = grant_n_q;
	assign o_local_xfer_state = xstate_q;
	assign o_local_end_kind = end_q;
	assign o_local_xfer_strobe_n = strobe_n_q;
	assign o_l_data_out = dout_q;
	assign o_burst_remaining = cnt_q;
	assign o_reqn = pci_q.reqn;
	assign o_framen = pci_q.framen;
	assign o_frame_oe = pci_q.frame_oe;
	assign o_irdyn = pci_q.irdyn;
	assign o_irdy_oe = pci_q.irdy_oe;
	assign o_ad = pci_q.ad;
	assign o_ad_oe = pci_q.ad_oe;
	assign o_cben = pci_q.cben;
	assign o_cbe_oe = pci_q.cbe_oe;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_last_done;
		phase_done && last_phase;
	endsequence

	AST_REQ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		req && state_q == pmb_pkg::PMB_IDLE |-> ##2 !o_reqn)
		else $error("bus request not raised");
	AST_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(state_q == pmb_pkg::PMB_LOAD) |-> o_local_xfer_state == pmb_pkg::ST_ADDR_LOAD)
		else $error("status not address loading");
	AST_FRAME: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		state_q == pmb_pkg::PMB_LOAD && gnt |=> !o_framen && o_ad_oe
		&& o_local_xfer_state == pmb_pkg::ST_BUS_XACT)
		else $error("frame not started");
	AST_IRDY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		state_q == pmb_pkg::PMB_DATA && rdy && !(phase_done && last_phase) |=> !o_irdyn)
		else $error("irdyn not held");
	AST_CNT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		phase_done |=> o_burst_remaining == $past(cnt_q) - pmb_pkg::CNT_ONE)
		else $error("burst count not decremented");
	AST_END: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_last_done |=> o_framen && !o_frame_oe && o_irdyn && !o_cbe_oe)
		else $error("frame not released");
	AST_TERM: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_last_done |=> o_local_xfer_state == pmb_pkg::ST_BUS_TERM
		&& o_local_end_kind == pmb_pkg::END_NORMAL ##1 !o_irdy_oe)
		else $error("termination not reported");
	AST_STB: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!write_q && phase_done && rdy |=> !o_local_xfer_strobe_n && o_l_data_out == $past(i_ad))
		else $error("read strobe missing");
	AST_WSTB: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		write_q && state_q == pmb_pkg::PMB_ADDR && rdy |=> !o_local_xfer_strobe_n)
		else $error("write strobe missing");
	AST_GNT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		gnt && bus_idle && req_seen_q |=> !o_local_grant_n)
		else $error("local grant not raised");
endmodule

// ### sim/pmb_far_model.sv
// Purpose: Arbiter and target standing on the bus side of the burst engine
// Assumes: No wait states and no target termination; frame, irdy and cbe lines pulled up
// Notes: Released data lines show the inverse of the last word
`timescale 1ns/1ps
module pmb_far_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Bus view
	input wire logic i_reqn,
	input wire logic i_framen,
	input wire logic i_irdyn,
	input wire logic [3:0] i_cben,
	input wire logic [1:0] i_gnt_wait,
	input wire logic [31:0] i_data_base,
	output logic o_gntn,
	output logic o_trdyn,
	output logic [31:0] o_ad,
	output logic o_ad_oe
);
	logic act_q;
	logic [7:0] wait_q;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_gntn <= 1'b1;
			o_trdyn <= 1'b1;
			o_ad_oe <= 1'b0;
			o_ad <= 32'h0000_0000;
			act_q <= 1'b0;
			wait_q <= 8'h00;
		end else begin
			// Grant comes promptly or late, as the bench picks
			wait_q <= i_reqn ? 8'h00 : wait_q + 8'h01;
			o_gntn <= i_reqn || (wait_q < {6'h00, i_gnt_wait});
			if (!act_q && !i_framen) begin
				act_q <= 1'b1;
				o_trdyn <= 1'b0;
				o_ad <= i_data_base;
				o_ad_oe <= !i_cben[0];
			end else if (act_q && !i_irdyn && !o_trdyn) begin
				if (i_framen) begin
					act_q <= 1'b0;
					o_trdyn <= 1'b1;
					o_ad_oe <= 1'b0;
					o_ad <= ~o_ad;
				end else begin
					o_ad <= o_ad_oe ? o_ad + 32'h0000_0001 : o_ad;
				end
			end
		end
	end
endmodule

// ### sim/pmb_master_burst_test.sv
// Purpose: Self-checking bench for the burst engine with random bursts
// Assumes: Far side modelled without wait states
// Notes: Expected read words are queued from the model's data base
`timescale 1ns/1ps
module pmb_master_burst_test;
	logic clk = 0, rst_n = 0, req_n = 1, rdy_n = 1, wr_q = 0;
	logic [31:0] l_ad = 0, base = 0, wexp = 0, dout, ad, m_ad;
	logic [3:0] l_cbe = 4'hf, state, endk, cben;
	logic [15:0] blen = 16'h0001, brem;
	logic [1:0] gwait = 0;
	logic gnt_l, strb_n, reqn, framen, fr_oe, irdyn, ir_oe, ad_oe, cbe_oe, gntn, trdyn, m_oe;
	wire bus_fr = fr_oe ? framen : 1'b1;
	wire bus_ir = ir_oe ? irdyn : 1'b1;
	wire [31:0] bus_ad = ad_oe ? ad : m_ad;
	wire [3:0] bus_cbe = cbe_oe ? cben : 4'hf;
	int errors = 0, n_tests = 0, n_strb = 0, n_gnt = 0;
	// Local grant needs the arbiter grant, an idle bus and req_seen_q, so it ends the clock after frame starts
	localparam int GNT_CYC = 3;
	logic [31:0] exp_q[$];
	pmb_master_burst pmb_master_burst_i (.i_clk(clk), .i_rst_n(rst_n),
		.i_local_req_32_n(req_n), .i_l_ad_in(l_ad), .i_local_cmd_be_in(l_cbe),
		.i_burst_len_in(blen), .i_local_ready_n(rdy_n), .o_local_grant_n(gnt_l),
		.o_local_xfer_state(state), .o_local_end_kind(endk), .o_local_xfer_strobe_n(strb_n),
		.o_l_data_out(dout), .o_burst_remaining(brem), .i_gntn(gntn), .i_framen(bus_fr),
		.i_irdyn(bus_ir), .i_trdyn(trdyn), .i_ad(bus_ad), .o_reqn(reqn), .o_framen(framen),
		.o_frame_oe(fr_oe), .o_irdyn(irdyn), .o_irdy_oe(ir_oe), .o_ad(ad), .o_ad_oe(ad_oe),
		.o_cben(cben), .o_cbe_oe(cbe_oe));
	pmb_far_model pmb_far_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_reqn(reqn),
		.i_framen(bus_fr), .i_irdyn(bus_ir), .i_cben(bus_cbe), .i_gnt_wait(gwait),
		.i_data_base(base), .o_gntn(gntn), .o_trdyn(trdyn), .o_ad(m_ad), .o_ad_oe(m_oe));
	initial forever #20 clk = ~clk;
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task wait_st(input logic [3:0] s);
		int k;
		k = 0;
		while (state !== s && k < 60) begin
			@(posedge clk);
			#1;
			k++;
		end
		check(state, s);
	endtask
	// ****************************************
	// Monitor of local strobes and grants
	// ****************************************
	always @(posedge clk) begin
		if (rst_n && strb_n === 1'b0) begin
			n_strb++;
			if (!wr_q) check(dout, exp_q.size() ? exp_q.pop_front() : ~dout);
		end
		if (rst_n && wr_q && bus_ir === 1'b0 && trdyn === 1'b0) begin
			check(bus_ad, wexp);
			wexp++;
		end
		if (rst_n && gnt_l === 1'b0) n_gnt++;
	end
	task burst(input logic wr, input int len);
		logic [31:0] b, a;
		logic [3:0] c;
		b = $urandom;
		a = $urandom;
		c = {3'($urandom), wr};
		@(posedge clk);
		wr_q <= wr;
		n_strb = 0;
		n_gnt = 0;
		for (int i = 0; i < len; i++) if (!wr) exp_q.push_back(b + i);
		base <= b;
		gwait <= 2'($urandom);
		req_n <= 1'b0;
		l_ad <= a;
		l_cbe <= c;
		blen <= 16'(len);
		rdy_n <= 1'b0;
		wait_st(pmb_pkg::ST_ADDR_LOAD);
		check(reqn, 1'b0);
		@(posedge clk);
		req_n <= 1'b1;
		l_cbe <= 4'h0;
		wexp = $urandom;
		l_ad <= wexp;
		#1;
		wait_st(pmb_pkg::ST_BUS_XACT);
		check({bus_fr, bus_cbe}, {1'b0, c});
		check(bus_ad, a);
		check(brem, 16'(len));
		// Local side streams one word a clock, as the design takes one each clock
		if (wr) repeat (len) begin
			@(posedge clk);
			l_ad <= l_ad + 32'h0000_0001;
		end
		wait_st(pmb_pkg::ST_BUS_TERM);
		check(endk, pmb_pkg::END_NORMAL);
		check({brem, irdyn, fr_oe, cbe_oe, ad_oe, m_oe}, {16'h0000, 5'b10000});
		wait_st(pmb_pkg::ST_IDLE);
		check({ir_oe, strb_n}, 2'b01);
		check(n_strb, len);
		check(n_gnt, GNT_CYC);
		check(exp_q.size(), 0);
		@(posedge clk);
		rdy_n <= 1'b1;
		$display("burst done: write %0d length %0d", wr, len);
	endtask
	initial begin
		void'($urandom(32'hcae2));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		check({reqn, framen, irdyn, strb_n, gnt_l, fr_oe, ir_oe, ad_oe}, 8'hf8);
		check({state, brem}, {pmb_pkg::ST_IDLE, pmb_pkg::CNT_ZERO});
		for (int t = 0; t < 10; t++) burst(t[0], t < 2 ? 1 : 1 + $urandom % 5);
		finish_test;
	end
	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		finish_test;
	end
endmodule
